/* mcgs_top.sv */
// Behaviour
// - Bit 0 records restart pointer usable
// - Bit 1 records pointer tied to error
// - Bit 2 set on each machine check outside shutdown
// - Check while bit 2 set enters shutdown
//
// Purpose: Per-thread machine check global status register
// Assumes: Detect and its qualifiers are valid in the same cycle
// Notes: Shutdown is left only through rstn_i
//
// Chosen here: the strobed register port and the placing of the registers.
`timescale 1ns/10ps
module mcgs_top
  import mcgs_pkg::*;
(
  // Clock and reset
  input wire logic ref_clk_i,
  input wire logic rstn_i,
  // Error detectors
  input wire logic mc_detect_i,
  input wire logic mc_restart_ok_i,
  input wire logic mc_err_assoc_i,
  // Register port
  input wire logic [11:0] reg_addr_i,
  input wire logic [63:0] reg_wdata_i,
  input wire logic reg_we_i,
  input wire logic reg_re_i,
  output logic [63:0] reg_rdata_o,
  // Core signalling
  output logic mce_o,
  output logic shutdown_o,
  output logic check_in_progress_o,
  output logic irq_o
);

  // ==========================================================
  // State
  mcgs_state_t s_q;
  mcgs_state_t s_d;
  mcgs_evt_if evt ();

  assign evt.detect = mc_detect_i;
  assign evt.in_progress = s_q.gsts[MCGS_BIT_INPROG];
  assign evt.in_shutdown = (s_q.mode == MCGS_SHUTDOWN);

  mcgs_decide u_decide (
    .evt(evt)
  );

  // ==========================================================
  // Next state
  always_comb begin
    s_d = s_q;
    s_d.mce = 1'b0;
    s_d.rdata = MCGS_RDATA_RST;
    if (reg_we_i) begin
      case (reg_addr_i)
        // Only the low three bits are stored
        MCGS_ADDR_GSTS: s_d.gsts = reg_wdata_i[MCGS_GSTS_W-1:0];
        MCGS_ADDR_IEN: s_d.ien = reg_wdata_i[MCGS_IEV_W-1:0];
        MCGS_ADDR_ICLR: s_d.ists = s_q.ists & ~reg_wdata_i[MCGS_IEV_W-1:0];
        default: s_d.ien = s_q.ien;
      endcase
    end
    // Hardware updates after software so a same-cycle event wins
    if (evt.raise) begin
      s_d.gsts[MCGS_BIT_RESTART] = mc_restart_ok_i;
      s_d.gsts[MCGS_BIT_ERRPTR] = mc_err_assoc_i;
      s_d.gsts[MCGS_BIT_INPROG] = 1'b1;
      s_d.mce = 1'b1;
      s_d.ists[MCGS_IEV_MCE] = 1'b1;
    end
    if (evt.escalate) begin
      s_d.mode = MCGS_SHUTDOWN;
      s_d.ists[MCGS_IEV_SHUT] = 1'b1;
    end
    s_d.irq = |(s_d.ists & s_d.ien);
    if (reg_re_i) begin
      case (reg_addr_i)
        MCGS_ADDR_GSTS: s_d.rdata = {61'h0, s_q.gsts};
        MCGS_ADDR_ISTS: s_d.rdata = {62'h0, s_q.ists};
        MCGS_ADDR_IEN: s_d.rdata = {62'h0, s_q.ien};
        default: s_d.rdata = MCGS_RDATA_RST;
      endcase
    end
  end

  always_ff @(posedge ref_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      s_q.mode <= MCGS_RUN;
      s_q.gsts <= MCGS_GSTS_RST;
      s_q.mce <= 1'b0;
      s_q.ists <= MCGS_IEV_RST;
      s_q.ien <= MCGS_IEV_RST;
      s_q.irq <= 1'b0;
      s_q.rdata <= MCGS_RDATA_RST;
    end else begin
      s_q <= s_d;
    end
  end

  // ==========================================================
  // Outputs
  assign reg_rdata_o = s_q.rdata;
  assign mce_o = s_q.mce;
  assign shutdown_o = s_q.mode;
  assign check_in_progress_o = s_q.gsts[MCGS_BIT_INPROG];
  assign irq_o = s_q.irq;

  // ==========================================================
  // Access decode
  // One strobe qualified by one register address
  function automatic logic reg_hit(input logic stb, input logic [11:0] a, input logic [11:0] t);
    reg_hit = stb && (a == t);
  endfunction

  // ==========================================================
  // Checks
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rstn_i);

  // Access decodes shared by several checks
  wire gsts_wr = reg_hit(reg_we_i, reg_addr_i, MCGS_ADDR_GSTS);
  wire gsts_rd = reg_hit(reg_re_i, reg_addr_i, MCGS_ADDR_GSTS);
  wire iclr_wr = reg_hit(reg_we_i, reg_addr_i, MCGS_ADDR_ICLR);
  wire ists_rd = reg_hit(reg_re_i, reg_addr_i, MCGS_ADDR_ISTS);
  wire ien_rd = reg_hit(reg_re_i, reg_addr_i, MCGS_ADDR_IEN);
  wire mapped_rd = gsts_rd || ists_rd || ien_rd;
  // Checks are judged from the visible flags, not from the decider
  wire first_check = mc_detect_i && !check_in_progress_o && !shutdown_o;
  wire second_check = mc_detect_i && check_in_progress_o && !shutdown_o;

  raise_sets_flag_a: assert property (
    first_check
      |=> check_in_progress_o && mce_o
  ) else $error("machine check did not set in-progress flag");

  restart_capture_a: assert property (
    first_check
      |=> s_q.gsts[MCGS_BIT_RESTART] == $past(mc_restart_ok_i)
  ) else $error("restart pointer flag not captured");

  error_capture_a: assert property (
    first_check
      |=> s_q.gsts[MCGS_BIT_ERRPTR] == $past(mc_err_assoc_i)
  ) else $error("error pointer flag not captured");

  shutdown_entry_a: assert property (
    second_check
      |=> shutdown_o && !mce_o
  ) else $error("second machine check did not enter shutdown");

  shutdown_hold_a: assert property (
    shutdown_o
      |=> shutdown_o && !mce_o
  ) else $error("shutdown left or exception delivered in shutdown");

  escalate_keeps_flags_a: assert property (
    second_check && !gsts_wr
      |=> s_q.gsts == $past(s_q.gsts)
  ) else $error("status flags changed on escalation");

  escalate_event_a: assert property (
    second_check
      |=> s_q.ists[MCGS_IEV_SHUT]
  ) else $error("shutdown event bit not set");

  mce_pulse_a: assert property (
    mce_o
      |=> !mce_o
  ) else $error("exception pulse longer than one cycle");

  no_spurious_mce_a: assert property (
    !first_check
      |=> !mce_o
  ) else $error("exception delivered without a first check");

  sw_clear_flag_a: assert property (
    gsts_wr && !reg_wdata_i[MCGS_BIT_INPROG] && !first_check
      |=> !check_in_progress_o
  ) else $error("in-progress flag not cleared by software");

  clear_then_deliver_a: assert property (
    mc_detect_i && !check_in_progress_o && !shutdown_o
      |=> mce_o && !shutdown_o
  ) else $error("check after a clear did not deliver an exception");

  reserved_zero_a: assert property (
    gsts_rd
      |=> reg_rdata_o[63:3] == 61'h0 && reg_rdata_o[2:0] == $past(s_q.gsts)
  ) else $error("reserved status bits not zero");

  status_write_a: assert property (
    gsts_wr && !first_check
      |=> s_q.gsts == $past(reg_wdata_i[MCGS_GSTS_W-1:0])
  ) else $error("status write did not land in the low bits");

  // Hardware set must beat a software clear in the same cycle
  set_wins_clear_a: assert property (
    first_check && iclr_wr
      |=> s_q.ists[MCGS_IEV_MCE]
  ) else $error("event lost against a same-cycle clear");

  clear_event_a: assert property (
    iclr_wr && !mc_detect_i
      |=> s_q.ists == ($past(s_q.ists) & ~$past(reg_wdata_i[MCGS_IEV_W-1:0]))
  ) else $error("event clear did not land");

  irq_follow_a: assert property (
    (|(s_q.ists & s_q.ien))
      |-> irq_o
  ) else $error("enabled event not on interrupt");

  irq_quiet_a: assert property (
    !(|(s_q.ists & s_q.ien))
      |-> !irq_o
  ) else $error("interrupt without an enabled event");

  read_once_a: assert property (
    !reg_re_i
      |=> reg_rdata_o == 64'h0
  ) else $error("read data stood outside its cycle");

  ists_readback_a: assert property (
    ists_rd
      |=> reg_rdata_o == {62'h0, $past(s_q.ists)}
  ) else $error("event status read back wrong");

  ien_readback_a: assert property (
    ien_rd
      |=> reg_rdata_o == {62'h0, $past(s_q.ien)}
  ) else $error("event enable read back wrong");

  // Write-only clear and unmapped addresses both read as zero
  unmapped_read_a: assert property (
    reg_re_i && !mapped_rd
      |=> reg_rdata_o == 64'h0
  ) else $error("unmapped read returned data");

endmodule

/* mcgs_pkg.sv */
// Purpose: Constants and types for the machine check global status block
// Assumes: 64-bit register port, 12-bit register address
// Notes: Status register sits at its machine-specific address
package mcgs_pkg;

  // ==========================================================
  // Register addresses
  localparam logic [11:0] MCGS_ADDR_GSTS = 12'h17a;
  localparam logic [11:0] MCGS_ADDR_ISTS = 12'h200;
  localparam logic [11:0] MCGS_ADDR_ICLR = 12'h201;
  localparam logic [11:0] MCGS_ADDR_IEN = 12'h202;

  // ==========================================================
  // Field layout and reset values
  localparam int MCGS_BIT_RESTART = 0;
  localparam int MCGS_BIT_ERRPTR = 1;
  localparam int MCGS_BIT_INPROG = 2;
  localparam int MCGS_GSTS_W = 3;
  localparam int MCGS_IEV_MCE = 0;
  localparam int MCGS_IEV_SHUT = 1;
  localparam int MCGS_IEV_W = 2;
  localparam logic [MCGS_GSTS_W-1:0] MCGS_GSTS_RST = 3'h0;
  localparam logic [MCGS_IEV_W-1:0] MCGS_IEV_RST = 2'h0;
  localparam logic [63:0] MCGS_RDATA_RST = 64'h0;

  // ==========================================================
  // Types
  typedef enum logic {MCGS_RUN, MCGS_SHUTDOWN} mcgs_mode_t;

  typedef struct packed {
    mcgs_mode_t mode;
    logic [MCGS_GSTS_W-1:0] gsts;
    logic mce;
    logic [MCGS_IEV_W-1:0] ists;
    logic [MCGS_IEV_W-1:0] ien;
    logic irq;
    logic [63:0] rdata;
  } mcgs_state_t;

endpackage

/* mcgs_evt_if.sv */
// Purpose: Carries a detected machine check to the escalation decoder
// Assumes: All signals in the ref_clk_i domain
// Notes: Purely combinational signals
`timescale 1ns/10ps
interface mcgs_evt_if;
  logic detect;
  logic in_progress;
  logic in_shutdown;
  logic raise;
  logic escalate;

  modport decide (
    input detect,
    input in_progress,
    input in_shutdown,
    output raise,
    output escalate
  );
  modport core (
    output detect,
    output in_progress,
    output in_shutdown,
    input raise,
    input escalate
  );
endinterface

/* mcgs_decide.sv */
// Purpose: Chooses between delivering a machine check and shutting down
// Assumes: Detect is a one-cycle pulse per machine check
// Notes: In shutdown every further check is dropped
`timescale 1ns/10ps
module mcgs_decide
  import mcgs_pkg::*;
(
  // Event carrier
  mcgs_evt_if.decide evt
);

  // ==========================================================
  // Decision
  assign evt.raise = evt.detect && !evt.in_progress && !evt.in_shutdown;
  // Second check while one is still being handled
  assign evt.escalate = evt.detect && evt.in_progress && !evt.in_shutdown;

endmodule

/* tb_top.sv */
// Purpose: Self-checking bench for the machine check global status block
// Assumes: Register port and detect pulses driven one cycle at a time
// Notes: Assertions live in the design files, so no separate checker
`timescale 1ns/10ps
module tb_top;
  import mcgs_pkg::*;

  // ==========================================================
  // Stimulus and observation
  logic ref_clk_i = 1'b0;
  logic rstn_i = 1'b0;
  logic mc_detect_i = 1'b0;
  logic mc_restart_ok_i = 1'b0;
  logic mc_err_assoc_i = 1'b0;
  logic [11:0] reg_addr_i = 12'h0;
  logic [63:0] reg_wdata_i = 64'h0;
  logic reg_we_i = 1'b0;
  logic reg_re_i = 1'b0;
  logic [63:0] reg_rdata_o;
  logic mce_o;
  logic shutdown_o;
  logic check_in_progress_o;
  logic irq_o;
  int n_fail = 0;
  int n_tests = 0;

  always #25 ref_clk_i = ~ref_clk_i;

  mcgs_top DUT (
    .ref_clk_i(ref_clk_i),
    .rstn_i(rstn_i),
    .mc_detect_i(mc_detect_i),
    .mc_restart_ok_i(mc_restart_ok_i),
    .mc_err_assoc_i(mc_err_assoc_i),
    .reg_addr_i(reg_addr_i),
    .reg_wdata_i(reg_wdata_i),
    .reg_we_i(reg_we_i),
    .reg_re_i(reg_re_i),
    .reg_rdata_o(reg_rdata_o),
    .mce_o(mce_o),
    .shutdown_o(shutdown_o),
    .check_in_progress_o(check_in_progress_o),
    .irq_o(irq_o)
  );

  // ==========================================================
  // Tasks
  task automatic print_verdict();
    $display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  task automatic chk(input logic [63:0] got, input logic [63:0] exp);
    n_tests++;
    if (got !== exp) begin
      n_fail++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Let outputs of the edge settle before anything is sampled
  task automatic tick();
    @(posedge ref_clk_i);
    #1;
  endtask

  task automatic wr(input logic [11:0] a, input logic [63:0] d);
    reg_addr_i <= a;
    reg_wdata_i <= d;
    reg_we_i <= 1'b1;
    tick();
    reg_we_i <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [63:0] exp);
    reg_addr_i <= a;
    reg_re_i <= 1'b1;
    tick();
    reg_re_i <= 1'b0;
    chk(reg_rdata_o, exp);
  endtask

  task automatic det(input logic ok, input logic assoc);
    mc_detect_i <= 1'b1;
    mc_restart_ok_i <= ok;
    mc_err_assoc_i <= assoc;
    tick();
    mc_detect_i <= 1'b0;
  endtask

  // ==========================================================
  // Tests
  initial begin
    repeat (10) @(posedge ref_clk_i);
    rstn_i <= 1'b1;
    tick();
    rd(MCGS_ADDR_GSTS, 64'h0);
    wr(MCGS_ADDR_GSTS, 64'hffff_ffff_ffff_ffff);
    rd(MCGS_ADDR_GSTS, 64'h7);
    wr(MCGS_ADDR_GSTS, 64'h0);
    rd(12'h3ff, 64'h0);
    wr(MCGS_ADDR_IEN, 64'h1);
    rd(MCGS_ADDR_IEN, 64'h1);
    det(1'b1, 1'b0);
    chk({63'h0, mce_o}, 64'h1);
    chk({63'h0, check_in_progress_o}, 64'h1);
    tick();
    chk({63'h0, irq_o}, 64'h1);
    rd(MCGS_ADDR_GSTS, 64'h5);
    // Idle edge so one strobe is never set twice in one step
    tick();
    rd(MCGS_ADDR_ISTS, 64'h1);
    wr(MCGS_ADDR_ICLR, 64'h1);
    tick();
    chk({63'h0, irq_o}, 64'h0);
    wr(MCGS_ADDR_GSTS, 64'h0);
    chk({63'h0, check_in_progress_o}, 64'h0);
    det(1'b0, 1'b1);
    chk({63'h0, mce_o}, 64'h1);
    rd(MCGS_ADDR_GSTS, 64'h6);
    // Second check while in progress escalates
    det(1'b1, 1'b1);
    chk({63'h0, mce_o}, 64'h0);
    chk({63'h0, shutdown_o}, 64'h1);
    rd(MCGS_ADDR_GSTS, 64'h6);
    tick();
    rd(MCGS_ADDR_ISTS, 64'h3);
    wr(MCGS_ADDR_IEN, 64'h2);
    tick();
    chk({63'h0, irq_o}, 64'h1);
    wr(MCGS_ADDR_IEN, 64'h0);
    tick();
    chk({63'h0, irq_o}, 64'h0);
    det(1'b0, 1'b0);
    chk({62'h0, shutdown_o, mce_o}, 64'h2);
    // Only a reset leaves shutdown
    rstn_i <= 1'b0;
    tick();
    chk({62'h0, shutdown_o, check_in_progress_o}, 64'h0);
    rstn_i <= 1'b1;
    tick();
    rd(MCGS_ADDR_ISTS, 64'h0);
    det(1'b1, 1'b1);
    chk({62'h0, shutdown_o, mce_o}, 64'h1);
    rd(MCGS_ADDR_GSTS, 64'h7);
    wr(MCGS_ADDR_GSTS, 64'h0);
    tick();
    // Event and its clear in one cycle: the event wins
    reg_addr_i <= MCGS_ADDR_ICLR;
    reg_wdata_i <= 64'h3;
    reg_we_i <= 1'b1;
    det(1'b0, 1'b0);
    reg_we_i <= 1'b0;
    chk({62'h0, shutdown_o, mce_o}, 64'h1);
    rd(MCGS_ADDR_ISTS, 64'h1);
    print_verdict();
  end

  // Whole sequence needs about 46 cycles
  initial begin
    repeat (2000) @(posedge ref_clk_i);
    n_fail++;
    print_verdict();
  end
endmodule
